//--- spa_pkg.sv
package spa_pkg;

  // register indices on the plain register port
  localparam logic [2:0] ADDR_TXSC   = 3'h0;
  localparam logic [2:0] ADDR_RXSC   = 3'h1;
  localparam logic [2:0] ADDR_BAUD   = 3'h2;
  localparam logic [2:0] ADDR_DIVL   = 3'h3;
  localparam logic [2:0] ADDR_DIVH   = 3'h4;
  localparam logic [2:0] ADDR_RXDATA = 3'h5;
  localparam logic [2:0] ADDR_TXDATA = 3'h6;
  localparam logic [2:0] ADDR_EVENTS = 3'h7;

  // transmit_status_control fields
  localparam int TX_CLOCK_MASTER_SELECT = 7;
  localparam int TX_NINE = 6;
  localparam int TX_EN   = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_BRK  = 3;
  localparam int TX_HIGH_SPEED_BAUD_SELECT = 2;
  localparam int TX_SHIFT_REGISTER_EMPTY = 1;
  localparam int TX_D9   = 0;

  // receive_status_control fields
  localparam int RX_SERIAL_PORT_ENABLE  = 7;
  localparam int RX_NINE  = 6;
  localparam int RX_SINGLE_RECEIVE_ENABLE  = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int RX_ADDRESS_FILTER_ENABLE = 3;

  // baud_rate_control fields
  localparam int BC_POL  = 4;
  localparam int BC_WIDE = 3;
  localparam int BC_WAKE = 1;
  localparam int BC_ABD  = 0;

  // writable bits and reset values
  localparam logic [7:0] TX_WMASK = 8'hFD;
  localparam logic [7:0] RX_WMASK = 8'hF8;
  localparam logic [7:0] BC_WMASK = 8'h1B;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0000;

  // divisor periods per bit: slow, medium and fast asynchronous rates
  localparam logic [6:0] TPB_SLOW = 7'h40;
  localparam logic [6:0] TPB_MID  = 7'h10;
  localparam logic [6:0] TPB_FAST = 7'h04;

  // frame lengths in bits
  localparam logic [3:0] BITS_A9  = 4'hB;
  localparam logic [3:0] BITS_A8  = 4'hA;
  localparam logic [3:0] BITS_D9  = 4'h9;
  localparam logic [3:0] BITS_D8  = 4'h8;
  localparam logic [3:0] BITS_BRK = 4'hE;
  localparam logic [13:0] LINE_IDLE = 14'h3FFF;

  // auto-rate: falling edges of the 0x55 pattern, and result shifts
  localparam logic [2:0] ABD_FALLS    = 3'h5;
  localparam logic [3:0] ABD_SH_SLOW  = 4'h9;
  localparam logic [3:0] ABD_SH_MID   = 4'h7;
  localparam logic [3:0] ABD_SH_FAST  = 4'h5;

  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef enum logic [0:0] {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } spa_tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } spa_rx_state_type;

endpackage

//--- spa_serial_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - async nine-bit address mode: pending only for ninth-bit-set characters
// - async nine-bit plus filter: load only if bit8 set
// - clearing continuous receive clears overrun
// - sync: clock master drives clock, slave takes it
// - nine-bit transmit sends extra bit from field
// - transmit enable; sync receive overrides transmit
// - mode bit selects synchronous or asynchronous
// - async break request sends break, self-clears when done
// - high-speed bit picks async rate multiplier
// - shift-empty reads one when idle, resets one
// - port enable claims pins, clear holds reset
// - nine-bit receive; extra bit stored, no parity
// - sync master single receive, self-clears after
// - continuous receive enables receiver, beats single
// - framing error follows top unread character
// - receiver idle flag drops during a character
// - polarity inverts async transmit data or picks edge
// - wide-divider bit selects 16 or 8 bits
// - async wake waits for falling edge, flags, self-clears
// - async auto-rate measures, self-clears, reports overflow
// - pending while enabled and characters unread
module spa_serial_port
  import spa_pkg::*;
(
  input  wire logic       clk_sys,              // system clock
  input  wire logic       sys_rst,              // sync reset, high
  input  wire logic [2:0] reg_addr,             // register index
  input  wire logic [7:0] reg_wdata,            // write data
  input  wire logic       reg_wr,               // write strobe
  input  wire logic       reg_rd,               // read strobe
  output logic      [7:0] reg_rdata,            // read data, next cycle
  input  wire logic       receive_data_pin_in,             // data pin level
  output logic            receive_data_pin_out,            // data pin drive value
  output logic            receive_data_pin_oe_n,           // data pin enable, low
  input  wire logic       transmit_clock_pin_in,             // clock pin level
  output logic            transmit_clock_pin_out,            // tx/clock drive value
  output logic            transmit_clock_pin_oe_n,           // tx/clock enable, low
  output logic            receive_pending_flag, // unread character
  output logic            transmit_ready        // holding reg empty
);

  logic [7:0]  txsc_r, txsc_nxt, rxsc_r, rxsc_nxt, bc_r, bc_nxt;
  logic [15:0] div_r, div_nxt, abd_div;
  logic        serial_port_enable, sync, master, pol, port_rst, div_wr, rd_rx, wr_tx;
  logic        brk_done, single_receive_enable_done, wake_hit, abd_done, fall;

  assign serial_port_enable     = rxsc_r[RX_SERIAL_PORT_ENABLE];
  assign sync     = txsc_r[TX_SYNC];
  assign master   = txsc_r[TX_CLOCK_MASTER_SELECT];
  assign pol      = bc_r[BC_POL];
  assign port_rst = sys_rst | ~serial_port_enable;
  assign div_wr   = reg_wr & (reg_addr == ADDR_DIVL | reg_addr == ADDR_DIVH);
  assign rd_rx    = reg_rd & (reg_addr == ADDR_RXDATA);
  assign wr_tx    = reg_wr & (reg_addr == ADDR_TXDATA);

  // control registers; a software write lands after any hardware clear
  always_comb begin
    txsc_nxt = txsc_r;
    rxsc_nxt = rxsc_r;
    bc_nxt   = bc_r;
    div_nxt  = div_r;
    if (brk_done) txsc_nxt[TX_BRK] = 1'b0;
    if (single_receive_enable_done) rxsc_nxt[RX_SINGLE_RECEIVE_ENABLE] = 1'b0;
    if (wake_hit) bc_nxt[BC_WAKE] = 1'b0;
    if (abd_done) begin
      bc_nxt[BC_ABD] = 1'b0;
      div_nxt = abd_div;
    end
    if (reg_wr) begin
      case (reg_addr)
        ADDR_TXSC: txsc_nxt = reg_wdata & TX_WMASK;
        ADDR_RXSC: rxsc_nxt = reg_wdata & RX_WMASK;
        ADDR_BAUD: bc_nxt   = reg_wdata & BC_WMASK;
        ADDR_DIVL: div_nxt[7:0]  = reg_wdata;
        ADDR_DIVH: div_nxt[15:8] = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      txsc_r <= CTRL_RST;
      rxsc_r <= CTRL_RST;
      bc_r   <= CTRL_RST;
      div_r  <= DIV_RST;
    end else begin
      txsc_r <= txsc_nxt;
      rxsc_r <= rxsc_nxt;
      bc_r   <= bc_nxt;
      div_r  <= div_nxt;
    end
  end

  // rate generator: one tick every divisor+1 clocks, restarted on a divisor write
  logic [15:0] brg_r, brg_nxt, div_eff;
  logic [6:0]  tpb;
  logic        tick;

  always_comb begin
    div_eff = bc_r[BC_WIDE] ? div_r : {8'h00, div_r[7:0]};
    case ({bc_r[BC_WIDE], txsc_r[TX_HIGH_SPEED_BAUD_SELECT]})
      2'b00:   tpb = TPB_SLOW;
      2'b11:   tpb = TPB_FAST;
      default: tpb = TPB_MID;
    endcase
    tick    = (brg_r >= div_eff);
    brg_nxt = tick ? 16'h0000 : brg_r + 16'h0001;
    if (div_wr) brg_nxt = 16'h0000;
  end

  always_ff @(posedge clk_sys) begin
    if (port_rst) brg_r <= 16'h0000;
    else brg_r <= brg_nxt;
  end

  // synchronous clock: generated by the master, watched by the slave
  spa_tx_state_type tx_st_r, tx_st_nxt;
  logic sck_r, sck_nxt, sck_ph_r, sck_ph_nxt, ck_prev_r, sync_edge;
  logic rx_sync_on, sck_run;

  assign sck_run = sync & master & (tx_st_r == TX_SHIFT | rx_sync_on);

  always_comb begin
    sck_nxt    = sck_r;
    sck_ph_nxt = sck_ph_r;
    sync_edge  = 1'b0;
    if (!sck_run) begin
      sck_nxt    = ~pol;                  // idle so the first edge is active
      sck_ph_nxt = 1'b0;
    end else if (tick) begin
      sck_ph_nxt = ~sck_ph_r;
      if (sck_ph_r) begin
        sck_nxt   = ~sck_r;
        sync_edge = (~sck_r == pol);
      end
    end
    if (sync && !master)
      sync_edge = (transmit_clock_pin_in != ck_prev_r) && (transmit_clock_pin_in == pol);
  end

  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      sck_r     <= 1'b0;
      sck_ph_r  <= 1'b0;
      ck_prev_r <= 1'b0;
    end else begin
      sck_r     <= sck_nxt;
      sck_ph_r  <= sck_ph_nxt;
      ck_prev_r <= transmit_clock_pin_in;
    end
  end

  // transmitter: holding register feeds a shift register, LSB first
  logic [13:0] tsr_r, tsr_nxt;
  logic [3:0]  tx_n_r, tx_n_nxt;
  logic [6:0]  tx_ph_r, tx_ph_nxt;
  logic [7:0]  hold_r, hold_nxt;
  logic        full_r, full_nxt, tx_brk_r, tx_brk_nxt, tx_on, tx_bit, tx_load;

  // receiving in sync mode takes the data pin from the transmitter
  assign tx_on = serial_port_enable & txsc_r[TX_EN]
               & ~(sync & (rxsc_r[RX_SINGLE_RECEIVE_ENABLE] | rxsc_r[RX_CONTINUOUS_RECEIVE_ENABLE]));

  always_comb begin
    tx_st_nxt  = tx_st_r;
    tsr_nxt    = tsr_r;
    tx_n_nxt   = tx_n_r;
    tx_ph_nxt  = tx_ph_r;
    hold_nxt   = hold_r;
    full_nxt   = full_r;
    tx_brk_nxt = tx_brk_r;
    brk_done   = 1'b0;
    tx_load    = 1'b0;
    tx_bit     = sync ? sync_edge : (tick && tx_ph_r == tpb - 7'h01);
    if (wr_tx && !full_r) begin
      hold_nxt = reg_wdata;
      full_nxt = 1'b1;
    end
    unique case (tx_st_r)
      TX_IDLE: if (tx_on && full_r) begin
        tx_load    = 1'b1;
        full_nxt   = 1'b0;
        tx_st_nxt  = TX_SHIFT;
        tx_ph_nxt  = 7'h00;
        tx_brk_nxt = ~sync & txsc_r[TX_BRK];
        if (sync) begin
          tsr_nxt  = {5'h1F, txsc_r[TX_D9], hold_r};
          tx_n_nxt = txsc_r[TX_NINE] ? BITS_D9 : BITS_D8;
        end else if (txsc_r[TX_BRK]) begin
          tsr_nxt  = {1'b1, 13'h0000};  // start, twelve zeros, stop
          tx_n_nxt = BITS_BRK;
        end else if (txsc_r[TX_NINE]) begin
          tsr_nxt  = {3'h7, 1'b1, txsc_r[TX_D9], hold_r, 1'b0};
          tx_n_nxt = BITS_A9;
        end else begin
          tsr_nxt  = {4'hF, 1'b1, hold_r, 1'b0};
          tx_n_nxt = BITS_A8;
        end
      end
      TX_SHIFT: begin
        if (!sync && tick)
          tx_ph_nxt = tx_bit ? 7'h00 : tx_ph_r + 7'h01;
        if (tx_bit) begin
          tsr_nxt  = {1'b1, tsr_r[13:1]};
          tx_n_nxt = tx_n_r - 4'h1;
          if (tx_n_r == 4'h1) begin
            tx_st_nxt = TX_IDLE;
            brk_done  = tx_brk_r;
          end
        end
        if (!tx_on) begin                // disabling aborts the frame
          tx_st_nxt = TX_IDLE;
          tsr_nxt   = LINE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      tx_st_r  <= TX_IDLE;
      tsr_r    <= LINE_IDLE;
      tx_n_r   <= 4'h0;
      tx_ph_r  <= 7'h00;
      hold_r   <= 8'h00;
      full_r   <= 1'b0;
      tx_brk_r <= 1'b0;
    end else begin
      tx_st_r  <= tx_st_nxt;
      tsr_r    <= tsr_nxt;
      tx_n_r   <= tx_n_nxt;
      tx_ph_r  <= tx_ph_nxt;
      hold_r   <= hold_nxt;
      full_r   <= full_nxt;
      tx_brk_r <= tx_brk_nxt;
    end
  end

  // pins: released while the port is off, shared per mode otherwise
  assign transmit_clock_pin_out  = sync ? sck_r : (tsr_r[0] ^ pol);
  assign transmit_clock_pin_oe_n = ~(serial_port_enable & (~sync | master));
  assign receive_data_pin_out  = tsr_r[0];
  assign receive_data_pin_oe_n = ~(serial_port_enable & sync & (tx_st_r == TX_SHIFT));
  assign transmit_ready = serial_port_enable & ~full_r;

  // receiver and its two-character buffer
  spa_rx_state_type rx_st_r, rx_st_nxt;
  logic [6:0] rx_ph_r, rx_ph_nxt;
  logic [3:0] rx_n_r, rx_n_nxt, rx_bits;
  logic [8:0] rsr_r, rsr_nxt;
  logic [7:0] fd_r [2];
  logic [7:0] fd_nxt [2];
  logic [1:0] f9_r, f9_nxt, ffe_r, ffe_nxt, fcnt_r, fcnt_nxt;
  logic       rxd_prev_r, overrun_error_flag_r, overrun_error_flag_nxt, wake_pend_r, wake_pend_nxt;
  logic       rx_async_on, rx_en, rx_bit, char_done, ch_framing_error_flag, ch9;
  logic       accept, pop, push;
  logic [7:0] ch;

  assign fall = rxd_prev_r & ~receive_data_pin_in;
  assign rx_async_on = serial_port_enable & ~sync & rxsc_r[RX_CONTINUOUS_RECEIVE_ENABLE]
                     & ~bc_r[BC_WAKE] & ~bc_r[BC_ABD];
  assign rx_sync_on  = serial_port_enable & sync
                     & (rxsc_r[RX_CONTINUOUS_RECEIVE_ENABLE] | (rxsc_r[RX_SINGLE_RECEIVE_ENABLE] & master));
  assign rx_en   = rx_async_on | rx_sync_on;
  assign rx_bits = rxsc_r[RX_NINE] ? BITS_D9 : BITS_D8;

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_ph_nxt = rx_ph_r;
    rx_n_nxt  = rx_n_r;
    rsr_nxt   = rsr_r;
    fd_nxt    = fd_r;
    f9_nxt    = f9_r;
    ffe_nxt   = ffe_r;
    fcnt_nxt  = fcnt_r;
    overrun_error_flag_nxt  = overrun_error_flag_r;
    wake_pend_nxt = wake_pend_r;
    char_done = 1'b0;
    ch_framing_error_flag   = 1'b0;
    single_receive_enable_done = 1'b0;
    wake_hit  = 1'b0;
    rx_bit    = sync ? sync_edge : (tick && rx_ph_r == tpb - 7'h01);
    if (!sync && tick && rx_st_r != RX_START)
      rx_ph_nxt = rx_bit ? 7'h00 : rx_ph_r + 7'h01;
    unique case (rx_st_r)
      RX_IDLE: begin
        rx_n_nxt = 4'h0;
        if (rx_async_on && !overrun_error_flag_r && fall) begin
          rx_st_nxt = RX_START;
          rx_ph_nxt = 7'h00;
        end else if (rx_sync_on && !overrun_error_flag_r) begin
          rx_st_nxt = RX_DATA;
        end
      end
      RX_START: if (tick) begin          // confirm the start bit mid-way
        rx_ph_nxt = rx_ph_r + 7'h01;
        if (rx_ph_r == (tpb >> 1) - 7'h01) begin
          rx_ph_nxt = 7'h00;
          rx_st_nxt = receive_data_pin_in ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: if (rx_bit) begin
        rsr_nxt  = {receive_data_pin_in, rsr_r[8:1]};
        rx_n_nxt = rx_n_r + 4'h1;
        if (rx_n_r == rx_bits - 4'h1) begin
          rx_st_nxt = sync ? RX_IDLE : RX_STOP;
          char_done = sync;
        end
      end
      RX_STOP: if (rx_bit) begin
        rx_st_nxt = RX_IDLE;
        char_done = 1'b1;
        ch_framing_error_flag   = ~receive_data_pin_in;
      end
    endcase
    if (!rx_en) rx_st_nxt = RX_IDLE;       // turning receive off aborts
    // eight-bit characters end up in the upper bits of the shifter
    ch  = rxsc_r[RX_NINE] ? rsr_nxt[7:0] : rsr_nxt[8:1];
    ch9 = rxsc_r[RX_NINE] & rsr_nxt[8];
    accept = ~(rxsc_r[RX_NINE] & rxsc_r[RX_ADDRESS_FILTER_ENABLE]
             & ~sync & ~ch9);
    push = char_done & accept;
    single_receive_enable_done = char_done & sync & master & rxsc_r[RX_SINGLE_RECEIVE_ENABLE]
              & ~rxsc_r[RX_CONTINUOUS_RECEIVE_ENABLE];
    pop = rd_rx & (fcnt_r != 2'h0);
    if (pop) begin                          // advance to the next entry
      fd_nxt[0]  = fd_r[1];
      f9_nxt[0]  = f9_r[1];
      ffe_nxt[0] = ffe_r[1];
      fcnt_nxt   = fcnt_r - 2'h1;
    end
    if (push) begin
      if (fcnt_r == FIFO_DEPTH && !pop) begin
        overrun_error_flag_nxt = 1'b1;                   // third character is lost
      end else begin
        fd_nxt[fcnt_nxt[0]]  = ch;
        f9_nxt[fcnt_nxt[0]]  = ch9;
        ffe_nxt[fcnt_nxt[0]] = ch_framing_error_flag;
        fcnt_nxt = fcnt_nxt + 2'h1;
      end
    end
    // level clear comes last so a sync single receive cannot re-arm it
    if (!rxsc_r[RX_CONTINUOUS_RECEIVE_ENABLE]) overrun_error_flag_nxt = 1'b0;
    if (rd_rx) wake_pend_nxt = 1'b0;
    if (serial_port_enable && !sync && bc_r[BC_WAKE] && fall) begin
      wake_hit      = 1'b1;
      wake_pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      rx_st_r     <= RX_IDLE;
      rx_ph_r     <= 7'h00;
      rx_n_r      <= 4'h0;
      rsr_r       <= 9'h000;
      fd_r[0]     <= 8'h00;
      fd_r[1]     <= 8'h00;
      f9_r        <= 2'h0;
      ffe_r       <= 2'h0;
      fcnt_r      <= 2'h0;
      rxd_prev_r  <= 1'b1;
      overrun_error_flag_r      <= 1'b0;
      wake_pend_r <= 1'b0;
    end else begin
      rx_st_r     <= rx_st_nxt;
      rx_ph_r     <= rx_ph_nxt;
      rx_n_r      <= rx_n_nxt;
      rsr_r       <= rsr_nxt;
      fd_r        <= fd_nxt;
      f9_r        <= f9_nxt;
      ffe_r       <= ffe_nxt;
      fcnt_r      <= fcnt_nxt;
      rxd_prev_r  <= receive_data_pin_in;
      overrun_error_flag_r      <= overrun_error_flag_nxt;
      wake_pend_r <= wake_pend_nxt;
    end
  end

  // pending cannot be written; it follows the buffer and the wake event
  assign receive_pending_flag = (rx_en & (fcnt_r != 2'h0))
                              | wake_pend_r;

  // auto-rate: time eight bit periods across five falling edges
  logic [25:0] abd_cnt_r, abd_cnt_nxt;
  logic [2:0]  abd_falls_r, abd_falls_nxt;
  logic [3:0]  abd_sh;
  logic        abd_ovf_r, abd_ovf_nxt, abd_on;

  assign abd_on = serial_port_enable & ~sync & bc_r[BC_ABD];

  always_comb begin
    abd_cnt_nxt   = abd_cnt_r;
    abd_falls_nxt = abd_falls_r;
    abd_ovf_nxt   = abd_ovf_r;
    abd_done      = 1'b0;
    case (tpb)
      TPB_SLOW: abd_sh = ABD_SH_SLOW;
      TPB_FAST: abd_sh = ABD_SH_FAST;
      default:  abd_sh = ABD_SH_MID;
    endcase
    abd_div = 16'(abd_cnt_r >> abd_sh) - 16'h0001;
    if (!abd_on) begin
      abd_falls_nxt = 3'h0;
    end else begin
      if (abd_falls_r != 3'h0) begin
        if (&abd_cnt_r) abd_ovf_nxt = 1'b1;
        else abd_cnt_nxt = abd_cnt_r + 26'h000_0001;
      end
      if (fall) begin
        abd_falls_nxt = abd_falls_r + 3'h1;
        if (abd_falls_r == 3'h0) begin
          abd_cnt_nxt = 26'h000_0000;
          abd_ovf_nxt = 1'b0;
        end
        if (abd_falls_r == ABD_FALLS - 3'h1) begin
          abd_done      = 1'b1;
          abd_falls_nxt = 3'h0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (port_rst) begin
      abd_cnt_r   <= 26'h000_0000;
      abd_falls_r <= 3'h0;
      abd_ovf_r   <= 1'b0;
    end else begin
      abd_cnt_r   <= abd_cnt_nxt;
      abd_falls_r <= abd_falls_nxt;
      abd_ovf_r   <= abd_ovf_nxt;
    end
  end

  // read port: data stand only in the cycle after the strobe
  logic [7:0] rdata_nxt, rdata_r;
  logic       shift_register_empty, rx_idle, top_valid;

  assign shift_register_empty      = (tx_st_r == TX_IDLE);
  assign rx_idle   = (rx_st_r == RX_IDLE);
  assign top_valid = (fcnt_r != 2'h0);

  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_TXSC:   rdata_nxt = {txsc_r[7:2], shift_register_empty, txsc_r[0]};
        ADDR_RXSC:   rdata_nxt = {rxsc_r[7:3], top_valid & ffe_r[0],
                                  overrun_error_flag_r, top_valid & f9_r[0]};
        ADDR_BAUD:   rdata_nxt = {abd_ovf_r, rx_idle, 1'b0, bc_r[4:3],
                                  1'b0, bc_r[1:0]};
        ADDR_DIVL:   rdata_nxt = div_r[7:0];
        ADDR_DIVH:   rdata_nxt = div_r[15:8];
        ADDR_RXDATA: rdata_nxt = top_valid ? fd_r[0] : 8'h00;
        ADDR_TXDATA: rdata_nxt = hold_r;
        default:     rdata_nxt = {6'h00, transmit_ready, receive_pending_flag};
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) rdata_r <= 8'h00;
    else rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_dropped_char;
    char_done && !accept && !pop;
  endsequence

  sequence s_last_read;
    rd_rx && fcnt_r == 2'h1 && !push && !wake_hit;
  endsequence

  a_filter_drops: assert property (
    s_dropped_char |=> fcnt_r == $past(fcnt_r) && !wake_pend_r
                       || $past(wake_hit))
    else $error("address filter let a character through");
  a_filter_ninth: assert property (
    push && rxsc_r[RX_NINE] && rxsc_r[RX_ADDRESS_FILTER_ENABLE] && !sync |-> ch9)
    else $error("address character without ninth bit set");
  a_overrun_clear: assert property (
    !rxsc_r[RX_CONTINUOUS_RECEIVE_ENABLE] |=> !overrun_error_flag_r)
    else $error("overrun kept after receive disable");
  a_shift_register_empty_reset: assert property (
    $past(sys_rst) |-> shift_register_empty && !full_r && reg_rdata == 8'h00
                       && transmit_clock_pin_oe_n && receive_data_pin_oe_n)
    else $error("shift register not empty after reset");
  a_break_clear: assert property (
    brk_done && !reg_wr |=> !txsc_r[TX_BRK])
    else $error("break request not cleared");
  a_single_clear: assert property (
    single_receive_enable_done && !reg_wr |=> !rxsc_r[RX_SINGLE_RECEIVE_ENABLE] ##1 rx_st_r == RX_IDLE)
    else $error("single receive not cleared");
  a_wake_flag: assert property (
    wake_hit && !reg_wr |=> receive_pending_flag && !bc_r[BC_WAKE])
    else $error("wake edge not flagged");
  a_port_held: assert property (
    !serial_port_enable && !reg_wr |=> fcnt_r == 2'h0 && shift_register_empty && rx_idle
                         && receive_data_pin_oe_n && transmit_clock_pin_oe_n)
    else $error("disabled port not held in reset");
  a_pending_drop: assert property (
    s_last_read |=> !receive_pending_flag)
    else $error("pending flag stuck after last read");
  a_sync_yield: assert property (
    tx_load |-> !(sync && (rxsc_r[RX_SINGLE_RECEIVE_ENABLE] || rxsc_r[RX_CONTINUOUS_RECEIVE_ENABLE])))
    else $error("transmit started over sync receive");
  a_baud_unimpl: assert property (
    reg_rd && reg_addr == ADDR_BAUD |=> !reg_rdata[5] && !reg_rdata[2])
    else $error("unimplemented bit read as one");

endmodule

//--- spa_line_model.sv
`timescale 1ns/1ps
// far-end transmitter on the shared line; idles high like a pulled-up bus
module spa_line_model (
  input  wire logic clk_sys, // system clock
  output logic      line     // serial line toward the port
);
  int bit_clk;
  initial begin
    bit_clk = 16;
    line    = 1'b1;
  end
  // start, nb data bits lsb first, stop; stop level always high here
  task automatic send(input logic [8:0] d, input int nb);
    for (int i = 0; i < nb + 2; i++) begin
      line <= (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : 1'b1;
      repeat (bit_clk) @(posedge clk_sys);
    end
  endtask
endmodule

//--- test_spa_serial_port.sv
`timescale 1ns/1ps
module test_spa_serial_port
  import spa_pkg::*;
;
  logic       clk_sys, sys_rst, reg_wr, reg_rd, rx_line;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic       txo, txoe, pend, dto, dtoe, trdy;
  logic [8:0] cap;
  int         n_mismatch, samples_checked, cyc;
  spa_line_model far (.clk_sys(clk_sys), .line(rx_line));
  spa_serial_port uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .receive_data_pin_in(rx_line), .receive_data_pin_out(dto),
    .receive_data_pin_oe_n(dtoe), .transmit_clock_pin_in(1'b1), .transmit_clock_pin_out(txo), .transmit_clock_pin_oe_n(txoe),
    .receive_pending_flag(pend), .transmit_ready(trdy));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk({1'b0, reg_rdata}, {1'b0, e});
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, well above the roughly 1700 cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    sys_rst = 1'b1;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(ADDR_TXSC, 8'h02);
    rd(ADDR_BAUD, 8'h40);
    wr(ADDR_BAUD, 8'h3C);
    rd(ADDR_BAUD, 8'h58);
    wr(ADDR_DIVL, 8'h00);
    wr(ADDR_BAUD, 8'h08);
    wr(ADDR_RXSC, 8'h80);
    wr(ADDR_RXSC, 8'hC0);
    wr(ADDR_RXSC, 8'hC8);
    wr(ADDR_RXSC, 8'hD8);
    chk(txoe, 1'b0);
    // async leaves the data pin released; holding register starts empty
    chk({dtoe, trdy}, 2'b11);
    far.send(9'h055, 9);
    chk(pend, 1'b0);
    far.send(9'h1A5, 9);
    chk(pend, 1'b1);
    rd(ADDR_RXSC, 8'hD9);
    rd(ADDR_RXDATA, 8'hA5);
    wr(ADDR_RXSC, 8'hD0);
    far.send(9'h033, 9);
    rd(ADDR_EVENTS, 8'h03);
    rd(ADDR_RXSC, 8'hD0);
    rd(ADDR_RXDATA, 8'h33);
    for (int i = 1; i < 4; i++) far.send(9'(i), 9);
    rd(ADDR_RXSC, 8'hD2);
    wr(ADDR_RXSC, 8'hC0);
    rd(ADDR_RXSC, 8'hC0);
    chk(pend, 1'b0);
    // nine-bit transmit; capture the line at each mid-bit
    wr(ADDR_TXSC, 8'h61);
    wr(ADDR_TXDATA, 8'h5A);
    for (int i = 0; i < 200 && txo; i++) @(posedge clk_sys);
    rd(ADDR_TXSC, 8'h61);
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < 9; i++) begin
      repeat (16) @(posedge clk_sys);
      cap[i] = txo;
    end
    chk(cap, 9'h15A);
    repeat (40) @(posedge clk_sys);
    rd(ADDR_TXSC, 8'h63);
    // break: thirteen low bit times, then the request clears itself
    wr(ADDR_TXSC, 8'h28);
    wr(ADDR_TXDATA, 8'h00);
    repeat (100) @(posedge clk_sys);
    chk({dto, txo}, 2'b00);
    repeat (140) @(posedge clk_sys);
    rd(ADDR_TXSC, 8'h22);
    // wake on the first falling edge, with the idle line inverted
    wr(ADDR_BAUD, 8'h1A);
    far.send(9'h000, 8);
    chk(pend, 1'b1);
    chk(txo, 1'b0);
    rd(ADDR_BAUD, 8'h58);
    rd(ADDR_RXDATA, 8'h01);
    chk(pend, 1'b0);
    summarize();
  end
endmodule
